// [design/disc_ctl_pkg.sv]
// Package with the constants and carrier types of the disc interface control block.
// Assumes a 40 MHz system clock and a host I/O bus decoded into instruction pulses.
package disc_ctl_pkg;

	localparam int unsigned CLK_MHZ         = 40;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned WORD_W          = 17;
	localparam int unsigned SECTOR_W        = 7;
	localparam int unsigned TRACK_W         = 7;
	localparam int unsigned FIFO_DEPTH      = 8;
	localparam int unsigned WORDS_PER_SECT  = 64;
	localparam logic [6:0]  LAST_SECTOR     = 7'h59;
	localparam int unsigned WORD_NS_60HZ    = 6000;
	localparam int unsigned WORD_NS_50HZ    = 7200;
	localparam int unsigned SECTOR_US_60HZ  = 375;
	localparam int unsigned SECTOR_US_50HZ  = 450;
	localparam int unsigned WORD_CYC_60HZ   = (WORD_NS_60HZ * CLK_MHZ) / 1000;
	localparam int unsigned WORD_CYC_50HZ   = (WORD_NS_50HZ * CLK_MHZ) / 1000;
	localparam int unsigned SECTOR_CYC_60HZ = SECTOR_US_60HZ * CLK_MHZ;
	localparam int unsigned SECTOR_CYC_50HZ = SECTOR_US_50HZ * CLK_MHZ;

	localparam int unsigned ST_SECT_FLAG  = 15;
	localparam int unsigned ST_NEXT_LSB   = 8;
	localparam int unsigned ST_READY      = 7;
	localparam int unsigned ST_RD_INH     = 6;
	localparam int unsigned ST_COINC      = 5;
	localparam int unsigned ST_ABORT      = 3;
	localparam int unsigned ST_WR_EN      = 2;
	localparam int unsigned ST_PARITY     = 1;
	localparam int unsigned ST_BUSY       = 0;
	localparam logic [15:0] STATUS_RESET  = 16'h0000;

	typedef struct packed {
		logic                write_op;
		logic [TRACK_W-1:0]  track;
		logic [SECTOR_W-1:0] sector;
	} control_word_type;

	typedef struct packed {
		logic                ready;
		logic                read_inhibit_n;
		logic                low_line;
		logic                sector_pulse;
		logic                word_pulse;
		logic                no_access;
		logic [SECTOR_W-1:0] next_sector;
	} disc_sense_type;

endpackage

// [design/word_fifo.sv]
// FIFO of parameterised width and depth with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
	parameter int unsigned WIDTH = 17,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             flush_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	wire              push = wr_valid_in && wr_ready_out;
	wire              pop  = rd_valid_out && rd_ready_in;

	assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_r != '0);
	assign rd_data_out  = mem_r[rp_r];

	always_ff @(posedge clk_in) begin
		if (push)
			mem_r[wp_r] <= wr_data_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || flush_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [design/disc_interface_status_control.sv]
// Control and status logic of the disc interface, with the disc word path.
// Assumes disc pins arrive asynchronously and instruction pulses come from the host bus clock.
`timescale 1ns/1ps
module disc_interface_status_control (
	input  wire logic                             clk_in,
	input  wire logic                             rst_in,
	input  wire logic                             control_word_output_instruction_in,
	input  wire disc_ctl_pkg::control_word_type   control_word_in,
	input  wire logic                             transfer_start_instruction_in,
	input  wire logic                             clear_control_instruction_in,
	input  wire logic                             status_load_instruction_in,
	output logic [disc_ctl_pkg::DATA_W-1:0]       status_word_out,
	output logic                                  status_valid_out,
	input  wire disc_ctl_pkg::disc_sense_type     disc_sense_in,
	input  wire logic                             protect_switch_in,
	input  wire logic [disc_ctl_pkg::TRACK_W-1:0] protect_limit_in,
	input  wire logic [disc_ctl_pkg::DATA_W-1:0]  host_wr_data_in,
	input  wire logic                             host_wr_valid_in,
	output logic                                  host_wr_ready_out,
	input  wire logic [disc_ctl_pkg::WORD_W-1:0]  disc_rd_word_in,
	output logic [disc_ctl_pkg::WORD_W-1:0]       disc_wr_word_out,
	output logic                                  disc_wr_strobe_out,
	output logic [disc_ctl_pkg::DATA_W-1:0]       host_rd_data_out,
	output logic                                  host_rd_valid_out,
	output logic                                  disc_write_gate_out
);
	import disc_ctl_pkg::*;

	typedef enum logic [1:0] {IDLE, SEEK, XFER, DRAIN} op_state_type;

	disc_sense_type   sense_s1_r;
	disc_sense_type   sense_r;
	logic [WORD_W-1:0] rdw_s1_r;
	logic [WORD_W-1:0] rdw_r;
	logic             prot_s1_r;
	logic             prot_r;
	disc_sense_type   sense_d_r;
	control_word_type cw_r;
	op_state_type     state_r;
	op_state_type     state_nxt;
	logic             coinc_r;
	logic             abort_r;
	logic             parity_r;
	logic [5:0]       word_idx_r;
	logic [DATA_W-1:0] status_nxt;
	logic [DATA_W-1:0] status_r;
	logic             status_valid_r;
	logic [WORD_W-1:0] wr_word_r;
	logic             wr_strobe_r;
	logic [DATA_W-1:0] rd_data_r;
	logic             rd_valid_r;
	logic             gate_r;

	// Both disc and switch are asynchronous to the host clock.
	always_ff @(posedge clk_in) begin
		sense_s1_r <= disc_sense_in;
		sense_r    <= sense_s1_r;
		rdw_s1_r   <= disc_rd_word_in;
		rdw_r      <= rdw_s1_r;
		prot_s1_r  <= protect_switch_in;
		prot_r     <= prot_s1_r;
		sense_d_r  <= sense_r;
	end

	// The disc word and sector marks are slow levels; edges give one-cycle events.
	wire word_evt   = sense_r.word_pulse && !sense_d_r.word_pulse;
	wire sector_evt = sense_r.sector_pulse && !sense_d_r.sector_pulse;
	wire coinc_hit  = sector_evt && (sense_r.next_sector == cw_r.sector)
	                  && (cw_r.sector <= LAST_SECTOR);
	wire last_word  = (word_idx_r == 6'(WORDS_PER_SECT - 1));
	wire busy       = (state_r != IDLE);
	wire track_prot = prot_r && (cw_r.track <= protect_limit_in);
	// Odd parity: a good word has an odd count of ones over all 17 bits.
	wire rd_par_bad = ~^rdw_r;

	wire              fifo_valid;
	wire [WORD_W-1:0] fifo_word;
	wire              do_xfer  = (state_r == XFER) && word_evt;
	wire              wr_take  = do_xfer && cw_r.write_op && fifo_valid && !track_prot;
	wire [WORD_W-1:0] par_word = {~^host_wr_data_in, host_wr_data_in};

	// The FIFO absorbs host bursts; when full the host is stalled through ready.
	word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.flush_in     (clear_control_instruction_in),
		.wr_data_in   (par_word),
		.wr_valid_in  (host_wr_valid_in),
		.wr_ready_out (host_wr_ready_out),
		.rd_data_out  (fifo_word),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (wr_take)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IDLE: begin
				if (transfer_start_instruction_in)
					state_nxt = SEEK;
			end
			SEEK: begin
				if (coinc_hit)
					state_nxt = XFER;
			end
			XFER: begin
				if (cw_r.write_op && word_evt && !fifo_valid && word_idx_r != '0)
					state_nxt = DRAIN;
				else if (word_evt && last_word && !cw_r.write_op)
					state_nxt = XFER;
			end
			DRAIN: begin
				if (sector_evt)
					state_nxt = IDLE;
			end
			default: state_nxt = IDLE;
		endcase
		// A clear or a new control word ends the transfer; busy holds to sector end.
		if (busy && (clear_control_instruction_in || control_word_output_instruction_in))
			state_nxt = DRAIN;
		if (state_r == DRAIN && transfer_start_instruction_in)
			state_nxt = DRAIN;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r    <= IDLE;
			cw_r       <= '0;
			word_idx_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (control_word_output_instruction_in)
				cw_r <= control_word_in;
			if (state_r == SEEK || sector_evt)
				word_idx_r <= '0;
			else if (do_xfer)
				word_idx_r <= word_idx_r + 6'h01;
		end
	end

	// Hardware sets win over the start that clears them in the same cycle.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			coinc_r  <= 1'b0;
			abort_r  <= 1'b0;
			parity_r <= 1'b0;
		end else begin
			if (coinc_hit && state_r == SEEK)
				coinc_r <= 1'b1;
			else if (transfer_start_instruction_in)
				coinc_r <= 1'b0;
			if (!sense_r.ready || sense_r.low_line)
				abort_r <= 1'b1;
			else if (transfer_start_instruction_in)
				abort_r <= 1'b0;
			if (do_xfer && !cw_r.write_op && rd_par_bad)
				parity_r <= 1'b1;
			else if (transfer_start_instruction_in)
				parity_r <= 1'b0;
		end
	end

	always_comb begin
		status_nxt                                  = STATUS_RESET;
		status_nxt[ST_SECT_FLAG]                    = sense_r.no_access;
		status_nxt[ST_NEXT_LSB +: SECTOR_W]         = sense_r.next_sector;
		status_nxt[ST_READY]                        = sense_r.ready;
		status_nxt[ST_RD_INH]                       = sense_r.read_inhibit_n;
		status_nxt[ST_COINC]                        = coinc_r;
		status_nxt[ST_ABORT]                        = abort_r;
		status_nxt[ST_WR_EN]                        = !track_prot;
		status_nxt[ST_PARITY]                       = parity_r;
		status_nxt[ST_BUSY]                         = busy;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			status_r       <= STATUS_RESET;
			status_valid_r <= 1'b0;
		end else begin
			status_valid_r <= status_load_instruction_in;
			if (status_load_instruction_in)
				status_r <= status_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_word_r   <= '0;
			wr_strobe_r <= 1'b0;
			rd_data_r   <= '0;
			rd_valid_r  <= 1'b0;
			gate_r      <= 1'b0;
		end else begin
			wr_strobe_r <= wr_take;
			if (wr_take)
				wr_word_r <= fifo_word;
			rd_valid_r <= do_xfer && !cw_r.write_op && !clear_control_instruction_in;
			if (do_xfer && !cw_r.write_op)
				rd_data_r <= rdw_r[DATA_W-1:0];
			gate_r <= (state_r == XFER) && cw_r.write_op && !track_prot;
		end
	end

	assign status_word_out     = status_r;
	assign status_valid_out    = status_valid_r;
	assign disc_wr_word_out    = wr_word_r;
	assign disc_wr_strobe_out  = wr_strobe_r;
	assign host_rd_data_out    = rd_data_r;
	assign host_rd_valid_out   = rd_valid_r;
	assign disc_write_gate_out = gate_r;
endmodule

// [test/disc_model.sv]
// Disc side model: word and sector pulses, next-sector count and read words.
// Assumes the bench clock; pins change at the falling edge.
`timescale 1ns/1ps
module disc_model #(
	parameter int WORD_CYC = 6,
	parameter int WPS      = 16
) (
	input  wire logic                       clk_in,
	input  wire logic                       ready_in,
	input  wire logic                       low_line_in,
	input  wire logic                       bad_par_in,
	output disc_ctl_pkg::disc_sense_type    sense_out,
	output logic [disc_ctl_pkg::WORD_W-1:0] rd_word_out
);
	import disc_ctl_pkg::*;
	int          cyc = 0;
	int          wrd = 0;
	logic [6:0]  cur = 7'h00;
	logic [15:0] dat = 16'h1234;
	logic [6:0]  nxt;
	// Sectors are kept short so that a whole revolution stays cheap to simulate.
	always @(negedge clk_in) begin
		cyc = (cyc + 1) % WORD_CYC;
		if (cyc == 0) begin
			wrd = (wrd + 1) % WPS;
			dat = dat + 16'h3A5B;
			if (wrd == 0)
				cur = nxt;
		end
	end
	assign nxt = (cur == LAST_SECTOR) ? 7'h00 : cur + 7'h01;
	assign sense_out = {ready_in, 1'b1, low_line_in, (wrd == 0 && cyc < 2), (cyc < 2),
		(wrd >= WPS - 2), nxt};
	assign rd_word_out = {~^dat ^ bad_par_in, dat};
endmodule

// [test/disc_ctl_props.sv]
// Assertions on the status, write and read ports of the disc control block.
// Assumes one clock domain with a synchronous active-high reset; bound below.
`timescale 1ns/1ps
module disc_ctl_props (
	input wire logic                            clk_in,
	input wire logic                            rst_in,
	input wire logic                            clear_control_instruction_in,
	input wire logic                            status_load_instruction_in,
	input wire disc_ctl_pkg::disc_sense_type    disc_sense_in,
	input wire logic [disc_ctl_pkg::DATA_W-1:0] status_word_out,
	input wire logic                            status_valid_out,
	input wire logic [disc_ctl_pkg::WORD_W-1:0] disc_wr_word_out,
	input wire logic                            disc_wr_strobe_out,
	input wire logic                            host_rd_valid_out,
	input wire logic                            disc_write_gate_out
);
	import disc_ctl_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [8:0] lvl_prev_r;
	logic [2:0] quiet_r;
	wire  [8:0] lvl = {disc_sense_in.ready, disc_sense_in.no_access, disc_sense_in.next_sector};
	// Sense pins pass a synchroniser, so a load is only judged once they have sat still.
	always_ff @(posedge clk_in) begin
		lvl_prev_r <= lvl;
		quiet_r <= (rst_in || lvl != lvl_prev_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
	end
	sequence s_settled_load;
		status_load_instruction_in && quiet_r >= 3'h5;
	endsequence
	sequence s_quiet_out;
		(!disc_wr_strobe_out && !host_rd_valid_out && !disc_write_gate_out) [*4];
	endsequence
	a_load_answer: assert property (status_load_instruction_in |=> status_valid_out)
		else $error("status load not answered");
	a_status_holds: assert property (!status_load_instruction_in |=> $stable(status_word_out))
		else $error("status word changed without a load");
	a_unused_zero: assert property (status_valid_out |-> !status_word_out[4])
		else $error("unused status bit set");
	a_ready_bit: assert property (s_settled_load |=> status_word_out[ST_READY] == $past(disc_sense_in.ready))
		else $error("ready bit wrong");
	a_next_addr: assert property (s_settled_load |=> {status_word_out[ST_SECT_FLAG],
		status_word_out[ST_NEXT_LSB +: SECTOR_W]} == $past(lvl[7:0]))
		else $error("next sector field wrong");
	a_abort_sticky: assert property ((s_settled_load and !disc_sense_in.ready) |=> status_word_out[ST_ABORT])
		else $error("abort flag not set");
	a_wr_parity: assert property (disc_wr_strobe_out |-> ^disc_wr_word_out)
		else $error("written word parity wrong");
	a_clear_stops: assert property (clear_control_instruction_in |-> ##2 s_quiet_out)
		else $error("transfer after clear");
endmodule
bind disc_interface_status_control disc_ctl_props u_props (.clk_in, .rst_in,
	.clear_control_instruction_in, .status_load_instruction_in, .disc_sense_in,
	.status_word_out, .status_valid_out, .disc_wr_word_out, .disc_wr_strobe_out,
	.host_rd_valid_out, .disc_write_gate_out);

// [test/tb.sv]
// Bench for the disc control block: status reads, write, read, abort and parity.
// Assumes disc_model on the disc pins and the checker bound to the design.
`timescale 1ns/1ps
module tb;
	import disc_ctl_pkg::*;
	logic             clk_in = 1'b0;
	logic             rst_in = 1'b1;
	logic [3:0]       ins = 4'h0;
	control_word_type cw = '0;
	disc_sense_type   sense;
	logic [6:0]       lim = 7'h03;
	logic [15:0]      wdat = 16'h0000;
	logic             wval = 1'b0, badp = 1'b0, rdy = 1'b1, low = 1'b0;
	logic             wrdy, strobe, sval, rval;
	logic [16:0]      wword, rdw;
	logic [15:0]      st, stat_w;
	logic [15:0]      q[$];
	int               mismatches = 0, comparisons = 0, cycles = 0, nrd = 0, seed = 32'hee06e603;
	always #12.5 clk_in = ~clk_in;
	disc_interface_status_control u_dut (.clk_in(clk_in), .rst_in(rst_in),
		.control_word_output_instruction_in(ins[3]), .control_word_in(cw),
		.transfer_start_instruction_in(ins[2]), .clear_control_instruction_in(ins[1]),
		.status_load_instruction_in(ins[0]), .status_word_out(stat_w), .status_valid_out(sval),
		.disc_sense_in(sense), .protect_switch_in(1'b1), .protect_limit_in(lim),
		.host_wr_data_in(wdat), .host_wr_valid_in(wval), .host_wr_ready_out(wrdy),
		.disc_rd_word_in(rdw), .disc_wr_word_out(wword), .disc_wr_strobe_out(strobe),
		.host_rd_data_out(), .host_rd_valid_out(rval), .disc_write_gate_out());
	disc_model u_disc (.clk_in(clk_in), .ready_in(rdy), .low_line_in(low), .bad_par_in(badp),
		.sense_out(sense), .rd_word_out(rdw));
	function automatic logic [16:0] par_word(input logic [15:0] d);
		return {~^d, d};
	endfunction
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic pulse(input int k);
		@(negedge clk_in);
		ins = 4'h1 << k;
		@(negedge clk_in);
		ins = 4'h0;
	endtask
	task automatic status;
		pulse(0);
		check(sval, 1'b1);
		st = stat_w;
	endtask
	task automatic push(input logic [15:0] d);
		@(negedge clk_in);
		wdat = d;
		wval = 1'b1;
		while (wrdy !== 1'b1) @(negedge clk_in);
		@(negedge clk_in);
		wval = 1'b0;
		q.push_back(d);
	endtask
	// Aims two sectors ahead so that coincidence cannot come before the first status read.
	task automatic start_op(input logic wr, input logic [6:0] trk);
		status;
		cw = {wr, trk, (st[14:8] >= LAST_SECTOR - 7'h01) ? st[14:8] + 7'h01 - LAST_SECTOR : st[14:8] + 7'h02};
		pulse(3);
		repeat ($random(seed) & 15) @(negedge clk_in);
		pulse(2);
	endtask
	task automatic wait_idle;
		status;
		for (int i = 0; i < 2000 && st[ST_BUSY]; i++) status;
		check(st[ST_BUSY], 1'b0);
		repeat (100) @(negedge clk_in);
	endtask
	// Outputs are sampled half a period after the edge that launches them.
	always @(negedge clk_in) begin
		cycles++;
		if (rval === 1'b1) nrd++;
		if (strobe === 1'b1) check(wword, par_word(q.pop_front()));
		if (cycles == 90000) begin
			mismatches++;
			report_and_stop;
		end
	end
	initial begin
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
		status;
		check({st[ST_READY], st[4]}, 2'b10);
		cw = {1'b1, lim, 7'h00};
		pulse(3);
		status;
		check(st[ST_WR_EN], 1'b0);
		for (int i = 0; i < 8; i++) push($random(seed));
		check(wrdy, 1'b0);
		start_op(1'b1, lim + 7'h01 + 7'($random(seed) & 32'h3F));
		status;
		check({st[ST_WR_EN], st[ST_COINC], st[ST_ABORT], st[ST_PARITY], st[ST_BUSY]}, 5'h11);
		for (int i = 0; i < 20000 && q.size() > 0; i++) @(negedge clk_in);
		status;
		check({st[ST_COINC], st[ST_BUSY]}, 2'b11);
		wait_idle;
		nrd = 0;
		start_op(1'b0, 7'($random(seed)));
		for (int i = 0; i < 20000 && nrd < 3; i++) @(negedge clk_in);
		badp = 1'b1;
		for (int i = 0; i < 200 && nrd < 6; i++) @(negedge clk_in);
		pulse(1);
		badp = 1'b0;
		repeat (2) @(negedge clk_in);
		nrd = 0;
		wait_idle;
		check({st[ST_PARITY], 16'(nrd)}, 17'h10000);
		rdy = 1'b0;
		repeat (10) @(negedge clk_in);
		status;
		check({st[ST_READY], st[ST_ABORT]}, 2'b01);
		rdy = 1'b1;
		repeat (10) @(negedge clk_in);
		status;
		check({st[ST_READY], st[ST_ABORT]}, 2'b11);
		start_op(1'b0, 7'h00);
		status;
		check({st[ST_ABORT], st[ST_PARITY], st[ST_BUSY]}, 3'b001);
		pulse(1);
		wait_idle;
		low = 1'b1;
		repeat (10) @(negedge clk_in);
		low = 1'b0;
		repeat (10) @(negedge clk_in);
		status;
		check(st[ST_ABORT], 1'b1);
		report_and_stop;
	end
endmodule
